// >>> xpdg_pkg.sv
package xpdg_pkg;
  // Address and field layout of the extension bus decode
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned NUM_WIN  = 9;
  // Window index order
  localparam int unsigned W_CAN1 = 0;
  localparam int unsigned W_CAN2 = 1;
  localparam int unsigned W_RTC  = 2;
  localparam int unsigned W_PWM  = 3;
  localparam int unsigned W_ASC  = 4;
  localparam int unsigned W_SSC  = 5;
  localparam int unsigned W_I2C  = 6;
  localparam int unsigned W_MISC = 7;
  localparam int unsigned W_RAM1 = 8;
  // Enable control bit positions
  localparam int unsigned EN_CAN1 = 0;
  localparam int unsigned EN_CAN2 = 1;
  localparam int unsigned EN_RAM1 = 2;
  localparam int unsigned EN_RAM2 = 3;
  localparam int unsigned EN_RTC  = 4;
  localparam int unsigned EN_PWM  = 6;
  localparam int unsigned EN_ASC  = 7;
  localparam int unsigned EN_SSC  = 8;
  localparam int unsigned EN_I2C  = 9;
  localparam int unsigned EN_MISC = 10;
  localparam int unsigned SYS_GLOBAL_EN = 2;
  // Window base and last addresses
  localparam logic [23:0] CAN1_LO = 24'h00ef00;
  localparam logic [23:0] CAN1_HI = 24'h00efff;
  localparam logic [23:0] CAN2_LO = 24'h00ee00;
  localparam logic [23:0] CAN2_HI = 24'h00eeff;
  localparam logic [23:0] RTC_LO  = 24'h00ed00;
  localparam logic [23:0] RTC_HI  = 24'h00edff;
  localparam logic [23:0] PWM_LO  = 24'h00ec00;
  localparam logic [23:0] PWM_HI  = 24'h00ecff;
  localparam logic [23:0] ASC_LO  = 24'h00e900;
  localparam logic [23:0] ASC_HI  = 24'h00e9ff;
  localparam logic [23:0] SSC_LO  = 24'h00e800;
  localparam logic [23:0] SSC_HI  = 24'h00e8ff;
  localparam logic [23:0] I2C_LO  = 24'h00ea00;
  localparam logic [23:0] I2C_HI  = 24'h00eaff;
  localparam logic [23:0] MISC_LO = 24'h00eb00;
  localparam logic [23:0] MISC_HI = 24'h00ebff;
  localparam logic [23:0] RAM1_LO = 24'h00e000;
  localparam logic [23:0] RAM1_HI = 24'h00e7ff;
  localparam logic [23:0] RAM2_LO = 24'h0f0000;
  localparam logic [23:0] RAM2_HI = 24'h0f7fff;
  localparam logic [23:0] STBY_HI = 24'h0f3fff;
  // Special function register areas, 512 bytes each
  localparam logic [23:0] SFR_LO  = 24'h00fe00;
  localparam logic [23:0] SFR_HI  = 24'h00ffff;
  localparam logic [23:0] EXTENDED_SPECIAL_REGS_LO = 24'h00f000;
  localparam logic [23:0] EXTENDED_SPECIAL_REGS_HI = 24'h00f1ff;
  // Enable control register address inside the extended area
  localparam logic [23:0] PERCON_ADDR = 24'h00f024;
  localparam logic [15:0] PERCON_RST  = 16'h0005;
  localparam logic [15:0] PERCON_MASK = 16'h07df;
  // Timing: two wait states at the documented 40 MHz bus rate
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned ACCESS_NS    = 100;
  localparam int unsigned XWAIT_STATES = 2;
  localparam int unsigned ACCESS_CYC   = (ACCESS_NS * CLK_MHZ) / 1000;
  localparam logic [4:0]  ACCESS_CNT   = 5'(ACCESS_CYC);
  // Port 4 segment line count
  localparam logic [3:0]  SEG_LINES_FULL = 4'h8;
  localparam logic [3:0]  SEG_LINES_CAN  = 4'h4;
  localparam logic [23:0] CS_SPAN_CAN    = 24'h0fffff;
endpackage : xpdg_pkg

// >>> xpdg_win_dec.sv
`timescale 1ns/1ps
// One decode window: range match gated by global and local enable
module xpdg_win_dec (
  input  wire logic [23:0] addr_in,
  input  wire logic [23:0] lo_in,
  input  wire logic [23:0] hi_in,
  input  wire logic        global_en_in,
  input  wire logic        local_en_in,
  output logic             hit_out,
  output logic             raw_out
);
  // Inclusive range compare
  assign raw_out = (addr_in >= lo_in) && (addr_in <= hi_in);
  // Claimed only when both enables stand
  assign hit_out = raw_out && global_en_in && local_en_in;
endmodule : xpdg_win_dec

// >>> xpdg_decode.sv
`timescale 1ns/1ps
//
// Contract
// - Lowest 16 kbyte of second RAM area from F0000h is standby RAM.
// - Extension RAM refused as system stack, register bank, or bit access; only stack and bit access are refused, register bank use is not checked.
// - Two 512-byte special register areas reserved, word-wide registers; only F024h is decoded, the rest of both areas goes to the external bus.
// - First CAN window EF00h-EFFFh needs global enable and bit 0.
// - Second CAN window EE00h-EEFFh needs global enable and bit 1.
// - Peripheral access: 16-bit words only, two wait states, 100ns.
// - Any CAN in use limits port 4 to four segment lines.
// - Clock window ED00h-EDFFh needs global enable and bit 4.
// - PWM window EC00h-ECFFh needs global enable and bit 6.
// - Async serial window E900h-E9FFh needs global enable and bit 7.
// - Sync serial window E800h-E8FFh needs global enable and bit 8.
// - I2C window EA00h-EAFFh needs global enable and bit 9.
// - Misc window EB00h-EBFFh needs global enable and bit 10.
// - Disabled peripheral claims no space, pins or interrupts.
// - Enable control register readable, writable, in extended area.
// - After end of init, clocks of disabled peripherals stop; RAM, misc keep.
// - Gated peripherals receive no reset after end of init.
// - Up to 16 Mbyte external memory addressable.
// - First RAM window goes external when its enable or global clear.
// - Bit 2 enables first RAM, bit 3 second; global is config bit 2.
module xpdg_decode
  import xpdg_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 req_in,
  input  wire logic                 wr_in,
  input  wire logic                 word_in,
  input  wire logic                 stack_in,
  input  wire logic                 bit_op_in,
  input  wire logic [xpdg_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [xpdg_pkg::DATA_W-1:0] wdata_in,
  input  wire logic [xpdg_pkg::DATA_W-1:0] sys_config_in,
  input  wire logic                 end_of_init_in,
  output logic                      ack_out,
  output logic                      err_out,
  output logic [xpdg_pkg::DATA_W-1:0] rdata_out,
  output logic [xpdg_pkg::NUM_WIN-1:0] sel_out,
  output logic                      ram2_sel_out,
  output logic                      standby_sel_out,
  output logic                      ext_sel_out,
  output logic                      reg_sel_out,
  output logic [xpdg_pkg::NUM_WIN-1:0] clk_en_out,
  output logic [xpdg_pkg::NUM_WIN-1:0] rst_allow_out,
  output logic [xpdg_pkg::NUM_WIN-1:0] pin_irq_own_out,
  output logic [3:0]                seg_lines_out,
  output logic [23:0]               cs_span_out
);
  import xpdg_pkg::*;

  typedef enum logic [1:0] {XPDG_IDLE, XPDG_WAIT, XPDG_DONE} xpdg_state_t;

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [15:0] percon_q;
  logic        end_of_init_instruction_done_q;
  xpdg_state_t st_q;
  logic [4:0]  cnt_q;
  logic [NUM_WIN-1:0] hit;
  logic [NUM_WIN-1:0] raw;
  logic [NUM_WIN-1:0] loc_en;
  logic        global_en;
  logic        ram2_hit;
  logic        reg_hit;
  logic        periph_hit;
  logic        bad_acc;
  logic [NUM_WIN-1:0] sel_q;
  logic        ram2_q, stby_q, ext_q, reg_q, ack_q, err_q;
  logic [15:0] rdata_q;
  logic [NUM_WIN-1:0] clk_en_q;
  logic [NUM_WIN-1:0] rst_allow_q;
  logic [NUM_WIN-1:0] own_q;
  logic [3:0]  seg_q;
  logic [23:0] span_q;

  // Window bounds indexed by window number
  function automatic logic [23:0] win_lo(input int unsigned i);
    unique case (i)
      W_CAN1:  win_lo = CAN1_LO;
      W_CAN2:  win_lo = CAN2_LO;
      W_RTC:   win_lo = RTC_LO;
      W_PWM:   win_lo = PWM_LO;
      W_ASC:   win_lo = ASC_LO;
      W_SSC:   win_lo = SSC_LO;
      W_I2C:   win_lo = I2C_LO;
      W_MISC:  win_lo = MISC_LO;
      default: win_lo = RAM1_LO;
    endcase
  endfunction : win_lo

  function automatic logic [23:0] win_hi(input int unsigned i);
    unique case (i)
      W_CAN1:  win_hi = CAN1_HI;
      W_CAN2:  win_hi = CAN2_HI;
      W_RTC:   win_hi = RTC_HI;
      W_PWM:   win_hi = PWM_HI;
      W_ASC:   win_hi = ASC_HI;
      W_SSC:   win_hi = SSC_HI;
      W_I2C:   win_hi = I2C_HI;
      W_MISC:  win_hi = MISC_HI;
      default: win_hi = RAM1_HI;
    endcase
  endfunction : win_hi

  // Enable bit that belongs to each window
  function automatic int unsigned win_bit(input int unsigned i);
    unique case (i)
      W_CAN1:  win_bit = EN_CAN1;
      W_CAN2:  win_bit = EN_CAN2;
      W_RTC:   win_bit = EN_RTC;
      W_PWM:   win_bit = EN_PWM;
      W_ASC:   win_bit = EN_ASC;
      W_SSC:   win_bit = EN_SSC;
      W_I2C:   win_bit = EN_I2C;
      W_MISC:  win_bit = EN_MISC;
      default: win_bit = EN_RAM1;
    endcase
  endfunction : win_bit

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign global_en = sys_config_in[SYS_GLOBAL_EN];

  // enables read live on every access
  for (genvar g = 0; g < NUM_WIN; g++) begin : g_win
    assign loc_en[g] = percon_q[win_bit(g)];
    xpdg_win_dec u_win (
      .addr_in      (addr_in),
      .lo_in        (win_lo(g)),
      .hi_in        (win_hi(g)),
      .global_en_in (global_en),
      .local_en_in  (loc_en[g]),
      .hit_out      (hit[g]),
      .raw_out      (raw[g])
    );
  end

  // second RAM area on bit 3
  assign ram2_hit = global_en && percon_q[EN_RAM2] &&
                    (addr_in >= RAM2_LO) && (addr_in <= RAM2_HI);
  // enable register in the extended area
  assign reg_hit  = (addr_in == PERCON_ADDR);
  assign periph_hit = |hit[W_MISC:W_CAN1];
  // no stack or bit access into extension RAM
  assign bad_acc = (periph_hit && !word_in) ||
                   ((hit[W_RAM1] || ram2_hit) && (stack_in || bit_op_in));

  // Access sequencer; peripherals stretch, RAM and register answer at once
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= XPDG_IDLE;
      cnt_q <= 5'h0;
    end else begin
      unique case (st_q)
        XPDG_IDLE: begin
          if (req_in && periph_hit && !bad_acc) begin
            st_q  <= XPDG_WAIT;
            cnt_q <= ACCESS_CNT - 5'h2;
          end else if (req_in) begin
            st_q <= XPDG_DONE;
          end
        end
        XPDG_WAIT: begin
          if (cnt_q == 5'h0) begin
            st_q <= XPDG_DONE;
          end else begin
            cnt_q <= cnt_q - 5'h1;
          end
        end
        XPDG_DONE: st_q <= XPDG_IDLE;
      endcase
    end
  end

  // Selects registered at request, held until answer
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      sel_q  <= '0;
      ram2_q <= 1'b0;
      stby_q <= 1'b0;
      ext_q  <= 1'b0;
      reg_q  <= 1'b0;
    end else if (st_q == XPDG_IDLE && req_in) begin
      sel_q  <= bad_acc ? '0 : hit;
      ram2_q <= ram2_hit && !bad_acc;
      stby_q <= ram2_hit && !bad_acc && (addr_in <= STBY_HI);
      // full 24-bit space reaches external bus
      ext_q  <= !(|hit) && !ram2_hit && !reg_hit;
      reg_q  <= reg_hit;
    end else if (st_q == XPDG_DONE) begin
      sel_q  <= '0;
      ram2_q <= 1'b0;
      stby_q <= 1'b0;
      ext_q  <= 1'b0;
      reg_q  <= 1'b0;
    end
  end

  // Answer strobe and error flag, one cycle
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= (st_q == XPDG_IDLE && req_in && !periph_hit) ||
               (st_q == XPDG_IDLE && req_in && bad_acc) ||
               (st_q == XPDG_WAIT && cnt_q == 5'h0);
      err_q <= st_q == XPDG_IDLE && req_in && bad_acc;
    end
  end

  // enable register write and read back
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      percon_q <= PERCON_RST;
      rdata_q  <= 16'h0;
    end else if (st_q == XPDG_IDLE && req_in && reg_hit) begin
      if (wr_in && word_in) begin
        percon_q <= wdata_in & PERCON_MASK;
      end
      rdata_q <= percon_q;
    end
  end

  // End of init seen once, held until reset
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      end_of_init_instruction_done_q <= 1'b0;
    end else if (end_of_init_in) begin
      end_of_init_instruction_done_q <= 1'b1;
    end
  end

  // Clock gating and reset suppression per peripheral
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_q    <= '1;
      rst_allow_q <= '1;
      own_q       <= '0;
    end else begin
      for (int i = 0; i < NUM_WIN; i++) begin
        // gate disabled peripherals, RAM and misc keep clocks
        clk_en_q[i] <= !end_of_init_instruction_done_q || loc_en[i] ||
                       (i == W_MISC) || (i == W_RAM1);
        // no reset into a gated peripheral
        rst_allow_q[i] <= !end_of_init_instruction_done_q || loc_en[i] ||
                          (i == W_MISC) || (i == W_RAM1);
        // pins and interrupts owned only when enabled
        own_q[i] <= global_en && loc_en[i];
      end
    end
  end

  // CAN use limits port 4 segment lines
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      seg_q  <= SEG_LINES_FULL;
      span_q <= 24'hffffff;
    end else if (global_en && (percon_q[EN_CAN1] || percon_q[EN_CAN2])) begin
      seg_q  <= SEG_LINES_CAN;
      span_q <= CS_SPAN_CAN;
    end else begin
      seg_q  <= SEG_LINES_FULL;
      span_q <= 24'hffffff;
    end
  end

  assign ack_out         = ack_q;
  assign err_out         = err_q;
  assign rdata_out       = rdata_q;
  assign sel_out         = sel_q;
  assign ram2_sel_out    = ram2_q;
  assign standby_sel_out = stby_q;
  assign ext_sel_out     = ext_q;
  assign reg_sel_out     = reg_q;
  assign clk_en_out      = clk_en_q;
  assign rst_allow_out   = rst_allow_q;
  assign pin_irq_own_out = own_q;
  assign seg_lines_out   = seg_q;
  assign cs_span_out     = span_q;

  // Assertions
  // peripheral answer after fixed wait
  periph_wait_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_q == XPDG_IDLE && req_in && periph_hit && !bad_acc) |-> !ack_q ##20 ack_q)
    else $error("peripheral access time wrong");
  can_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_q == XPDG_IDLE && req_in && raw[W_CAN1] && !(global_en && percon_q[EN_CAN1]))
      |=> !sel_q[W_CAN1])
    else $error("first CAN claimed while disabled");
  ext_fwd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_q == XPDG_IDLE && req_in && !global_en && !reg_hit) |=> ext_q)
    else $error("access not forwarded");
  // gated clock after end of init
  clk_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (end_of_init_instruction_done_q && !percon_q[EN_RTC]) |=> !clk_en_q[W_RTC])
    else $error("disabled clock still running");
  no_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    !clk_en_q[W_CAN2] |-> !rst_allow_q[W_CAN2])
    else $error("reset allowed to gated block");
  seg_limit_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (global_en && percon_q[EN_CAN1]) |=> seg_q == SEG_LINES_CAN)
    else $error("segment lines not limited");
  stby_sel_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    stby_q |-> ram2_q)
    else $error("standby select outside second RAM");
  ram_stack_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_q == XPDG_IDLE && req_in && hit[W_RAM1] && stack_in) |=> err_q && ack_q)
    else $error("stack access not refused");
  reg_rd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_q == XPDG_IDLE && req_in && reg_hit && !wr_in) |=> rdata_q == $past(percon_q))
    else $error("register readback wrong");
  periph_cov_c: cover property (@(posedge clk_sys_in) st_q == XPDG_WAIT ##1 ack_q);
  ext_cov_c:    cover property (@(posedge clk_sys_in) ext_q && ack_q);
  gate_cov_c:   cover property (@(posedge clk_sys_in) end_of_init_instruction_done_q && !clk_en_q[W_CAN1]);
endmodule : xpdg_decode

// >>> xpdg_ext_model.sv
`timescale 1ns/1ps
// External bus side: counts the accesses the decoder hands out
module xpdg_ext_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        ext_sel_in,
  output logic      [15:0] ext_count_out
);
  logic ext_sel_q;

  // Edge memory, so a select held for several cycles counts once
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_sel_q <= 1'b0;
    end else begin
      ext_sel_q <= ext_sel_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_count_out <= 16'h0000;
    end else if (ext_sel_in && !ext_sel_q) begin
      ext_count_out <= ext_count_out + 16'h0001;
    end
  end
endmodule : xpdg_ext_model

// >>> xpdg_decode_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module xpdg_decode_tb_top;
  import xpdg_pkg::*;
  localparam logic [23:0] LO_T [9] = '{CAN1_LO, CAN2_LO, RTC_LO, PWM_LO, ASC_LO, SSC_LO,
                                       I2C_LO, MISC_LO, RAM1_LO};
  localparam logic [23:0] HI_T [9] = '{CAN1_HI, CAN2_HI, RTC_HI, PWM_HI, ASC_HI, SSC_HI,
                                       I2C_HI, MISC_HI, RAM1_HI};
  localparam int unsigned EN_T [9] = '{EN_CAN1, EN_CAN2, EN_RTC, EN_PWM, EN_ASC, EN_SSC,
                                       EN_I2C, EN_MISC, EN_RAM1};
  logic                clk_sys_in, rst_n_in, req_in, wr_in, word_in, stack_in, bit_op_in;
  logic                end_of_init_in, ack_out, err_out, ram2_sel_out, standby_sel_out;
  logic                ext_sel_out, reg_sel_out;
  logic [ADDR_W-1:0]   addr_in;
  logic [DATA_W-1:0]   wdata_in, sys_config_in, rdata_out;
  logic [NUM_WIN-1:0]  sel_out, clk_en_out, rst_allow_out, pin_irq_own_out;
  logic [3:0]          seg_lines_out;
  logic [23:0]         cs_span_out;
  logic [15:0]         ext_count;
  int                  n_fail, samples_checked, n_ext, r_cyc;
  logic [NUM_WIN-1:0]  r_sel;
  logic                r_ext, r_reg, r_err, r_ram2, r_stby;
  logic [DATA_W-1:0]   r_rdata;

  xpdg_decode i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .wr_in(wr_in), .word_in(word_in), .stack_in(stack_in), .bit_op_in(bit_op_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .sys_config_in(sys_config_in),
    .end_of_init_in(end_of_init_in), .ack_out(ack_out), .err_out(err_out),
    .rdata_out(rdata_out), .sel_out(sel_out), .ram2_sel_out(ram2_sel_out),
    .standby_sel_out(standby_sel_out), .ext_sel_out(ext_sel_out), .reg_sel_out(reg_sel_out),
    .clk_en_out(clk_en_out), .rst_allow_out(rst_allow_out),
    .pin_irq_own_out(pin_irq_own_out), .seg_lines_out(seg_lines_out),
    .cs_span_out(cs_span_out));

  xpdg_ext_model i_ext (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ext_sel_in(ext_sel_out), .ext_count_out(ext_count));

  // Free running 200 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // One access; results are sampled in the ack cycle, while selects still stand
  task automatic acc(input logic [23:0] a, input logic w, input logic wd, input logic stk,
                     input logic bo, input logic [15:0] d);
    int k;
    @(negedge clk_sys_in);
    req_in    = 1'b1;
    addr_in   = a;
    wr_in     = w;
    word_in   = wd;
    stack_in  = stk;
    bit_op_in = bo;
    wdata_in  = d;
    @(negedge clk_sys_in);
    req_in = 1'b0;
    k = 0;
    while (ack_out !== 1'b1 && k < 40) begin
      @(negedge clk_sys_in);
      k++;
    end
    if (k >= 40) begin
      n_fail++;
      $display("BAD %0t no answer", $time);
      conclude();
    end
    r_cyc   = k + 1; // Cycles from take edge to answer
    r_sel   = sel_out;
    r_ext   = ext_sel_out;
    r_reg   = reg_sel_out;
    r_err   = err_out;
    r_ram2  = ram2_sel_out;
    r_stby  = standby_sel_out;
    r_rdata = rdata_out;
  endtask : acc

  task automatic wreg(input logic [15:0] d);
    acc(PERCON_ADDR, 1'b1, 1'b1, 1'b0, 1'b0, d);
    // Derived outputs are registered one edge after the write lands
    @(negedge clk_sys_in);
  endtask : wreg

  // Ownership expected from global and local enables
  function automatic logic [8:0] exp_en(input logic [15:0] pc, input logic g);
    logic [8:0] e;
    for (int i = 0; i < 9; i++) e[i] = g & pc[EN_T[i]];
    return e;
  endfunction : exp_en

  // Clocks after end of init; misc block and RAM always keep theirs
  function automatic logic [8:0] exp_clk(input logic [15:0] pc);
    logic [8:0] e;
    for (int i = 0; i < 9; i++) e[i] = (i >= 7) ? 1'b1 : pc[EN_T[i]];
    return e;
  endfunction : exp_clk

  // Main sequence
  initial begin
    logic [23:0] ra [4];
    rst_n_in = 1'b0; req_in = 1'b0; wr_in = 1'b0; word_in = 1'b0; stack_in = 1'b0;
    bit_op_in = 1'b0; addr_in = '0; wdata_in = '0; sys_config_in = '0;
    end_of_init_in = 1'b0; n_fail = 0; samples_checked = 0; n_ext = 0;
    repeat (8) @(negedge clk_sys_in);
    `CHK(clk_en_out, 9'h1ff)
    `CHK(rst_allow_out, 9'h1ff)
    `CHK(seg_lines_out, SEG_LINES_FULL)
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    sys_config_in = 16'h0004;
    acc(PERCON_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK(r_rdata, PERCON_RST)
    `CHK(r_reg, 1'b1)
    wreg(16'hffff);
    acc(PERCON_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK(r_rdata, PERCON_MASK)
    `CHK(pin_irq_own_out, exp_en(PERCON_MASK, 1'b1))
    `CHK(cs_span_out, CS_SPAN_CAN)
    // Each window claimed, then dropped to the external bus by its own bit
    for (int i = 0; i < 9; i++) begin
      wreg(PERCON_MASK);
      acc(LO_T[i], 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
      `CHK(r_sel, 9'h001 << i)
      `CHK(r_cyc, (i == 8) ? 1 : int'(ACCESS_CYC))
      acc(HI_T[i] - 24'h1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h5a5a);
      `CHK(r_sel, 9'h001 << i)
      wreg(PERCON_MASK & ~(16'h0001 << EN_T[i]));
      `CHK(pin_irq_own_out[i], 1'b0)
      acc(LO_T[i], 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
      `CHK(r_sel, 9'h000)
      `CHK(r_ext, 1'b1)
      n_ext++;
    end
    wreg(16'h07dc);
    `CHK(seg_lines_out, SEG_LINES_FULL)
    `CHK(cs_span_out, 24'hffffff)
    wreg(PERCON_MASK);
    sys_config_in = 16'h0000;
    acc(CAN1_LO, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK(r_ext, 1'b1)
    n_ext++;
    `CHK(pin_irq_own_out, 9'h000)
    sys_config_in = 16'h0004;
    acc(PWM_LO, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    `CHK(r_err, 1'b1)
    `CHK(r_sel, 9'h000)
    acc(RAM1_LO, 1'b1, 1'b1, 1'b1, 1'b0, 16'h1234);
    `CHK(r_err, 1'b1)
    acc(RAM2_LO, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0000);
    `CHK(r_err, 1'b1)
    // Standby part is the low 16 kbyte of the second RAM area
    ra = '{RAM2_LO, STBY_HI - 24'h1, STBY_HI + 24'h1, RAM2_HI - 24'h1};
    for (int i = 0; i < 4; i++) begin
      acc(ra[i], 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
      `CHK(r_ram2, 1'b1)
      `CHK(r_stby, (i < 2) ? 1'b1 : 1'b0)
    end
    acc(24'h100000, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK(r_ext, 1'b1)
    n_ext++;
    wreg(16'h0015);
    `CHK(clk_en_out, 9'h1ff)
    @(negedge clk_sys_in);
    end_of_init_in = 1'b1;
    @(negedge clk_sys_in);
    end_of_init_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    `CHK(clk_en_out, exp_clk(16'h0015))
    `CHK(rst_allow_out, exp_clk(16'h0015))
    wreg(16'h0002);
    repeat (2) @(negedge clk_sys_in);
    `CHK(clk_en_out, exp_clk(16'h0002))
    `CHK(rst_allow_out, exp_clk(16'h0002))
    `CHK(ext_count, 16'(n_ext))
    conclude();
  end
endmodule : xpdg_decode_tb_top
